// ---- design/opc_panel.sv ----
// Operator panel control: buttons, lamps, run mode, attention flag.
// Assumes panel pins are asynchronous and debounced; sequencer signals
// and the register port run on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module opc_panel import opc_pkg::*; #(
  parameter int WORD_W = 24
) (
  input wire logic clk_sys,
  input wire logic rst,
  // Asynchronous panel and drive pins.
  input wire logic mode_button,
  input wire logic clear_button_op,
  input wire logic clear_button_mnt,
  input wire logic start_button_op,
  input wire logic start_button_mnt,
  input wire logic attention_button_op,
  input wire logic attention_button_mnt,
  input wire logic tape_rewind_button,
  input wire logic tape_bot_sense,
  input wire logic single_step_select,
  input wire logic [1:0] micro_source_sel,
  // Sequencer side, same clock.
  input wire logic halt_request,
  input wire logic attention_flag_reset,
  input wire logic micro_fetch_req,
  input wire logic [WORD_W-1:0] tape_word,
  // Register port.
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_ff,
  output logic irq_ff,
  // Panel and sequencer outputs.
  output logic tape_micro_mode_ff,
  output logic mode_lamp_ff,
  output logic system_clear_ff,
  output logic run_enable_ff,
  output logic test_state_lamp_ff,
  output logic operator_attention_flag_ff,
  output logic rewind_start_ff,
  output logic tape_start_lamp_ff,
  output logic cache_fetch_ff,
  output logic mir_load_ff,
  output logic [WORD_W-1:0] mir_data_ff
);

  // Rising edge of a synchronised level against its previous value.
  function automatic logic rise(input logic now_lvl, input logic old_lvl);
    rise = now_lvl & ~old_lvl;
  endfunction : rise

  logic [PIN_COUNT-1:0] pin_meta_ff; // First synchroniser stage, read only by the second.
  logic [PIN_COUNT-1:0] pin_sync_ff; // Second stage, safe for logic.
  logic [PIN_COUNT-1:0] pin_prev_ff; // Previous synchronised value for edge detection.
  logic clr_lvl; // Merged clear level from both panels.
  logic start_lvl; // Merged start level.
  logic attn_lvl; // Merged attention level.
  logic clr_prev; // Merged clear level one cycle ago.
  logic start_prev; // Merged start level one cycle ago.
  logic attn_prev; // Merged attention level one cycle ago.
  logic mode_press; // One-cycle pulse per mode press.
  logic clr_press; // One-cycle pulse per clear press.
  logic start_press; // One-cycle pulse per start press.
  logic attn_press; // One-cycle pulse per attention press.
  logic rewind_press; // One-cycle pulse per rewind press.
  logic bot_rise; // Beginning of tape just became sensed.
  opc_run_t run_ff; // Run sequencing state.
  opc_run_t nxt_run; // Next run state.
  logic [EV_COUNT-1:0] event_ff; // Sticky event bits.
  logic [EV_COUNT-1:0] mask_ff; // Interrupt enables.
  logic [EV_COUNT-1:0] ev_now; // Events raised this cycle.
  logic lamp_test_ff; // Software lamp test.
  logic wr_state; // Write strobe decode helpers.
  logic wr_event;
  logic wr_mask;
  logic wr_ctrl;
  logic sw_attn_reset; // Software reset of the attention flag.
  logic test_cond; // Abnormal run condition.

  // Two flip-flops on every asynchronous pin; the edge stage reads stage two.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
      pin_prev_ff <= '0;
    end else begin
      pin_meta_ff <= {micro_source_sel, single_step_select, tape_bot_sense,
                      tape_rewind_button, attention_button_mnt, attention_button_op,
                      start_button_mnt, start_button_op, clear_button_mnt,
                      clear_button_op, mode_button};
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  // Duplicated buttons are merged before edge detection, so a press held on
  // both panels at once, or overlapping, yields a single pulse.
  always_comb begin
    clr_lvl = pin_sync_ff[PIN_CLR_OP] | pin_sync_ff[PIN_CLR_MNT];
    start_lvl = pin_sync_ff[PIN_START_OP] | pin_sync_ff[PIN_START_MNT];
    attn_lvl = pin_sync_ff[PIN_ATTN_OP] | pin_sync_ff[PIN_ATTN_MNT];
    clr_prev = pin_prev_ff[PIN_CLR_OP] | pin_prev_ff[PIN_CLR_MNT];
    start_prev = pin_prev_ff[PIN_START_OP] | pin_prev_ff[PIN_START_MNT];
    attn_prev = pin_prev_ff[PIN_ATTN_OP] | pin_prev_ff[PIN_ATTN_MNT];
    mode_press = rise(pin_sync_ff[PIN_MODE], pin_prev_ff[PIN_MODE]);
    clr_press = rise(clr_lvl, clr_prev);
    start_press = rise(start_lvl, start_prev);
    attn_press = rise(attn_lvl, attn_prev);
    rewind_press = rise(pin_sync_ff[PIN_REWIND], pin_prev_ff[PIN_REWIND]);
    bot_rise = rise(pin_sync_ff[PIN_BOT], pin_prev_ff[PIN_BOT]);
  end

  // Register write decode.
  always_comb begin
    wr_state = reg_wr & (reg_addr == OFS_STATE);
    wr_event = reg_wr & (reg_addr == OFS_EVENT);
    wr_mask = reg_wr & (reg_addr == OFS_MASK);
    wr_ctrl = reg_wr & (reg_addr == OFS_CTRL);
    sw_attn_reset = wr_ctrl & reg_wdata[CT_ATTN_RESET];
  end

  // Operating mode toggles on every press and holds in between. Clear does
  // not touch it, since the operator picks the mode before clearing.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tape_micro_mode_ff <= 1'b0;
    end else if (mode_press) begin
      tape_micro_mode_ff <= ~tape_micro_mode_ff;
    end
  end

  // The lamp in the mode button mirrors the new mode in the same cycle it
  // is stored, so outside the lamp test it never disagrees with the mode for a visible time.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_lamp_ff <= 1'b0;
    end else begin
      // The lamp test term uses the value being written this cycle, so the
      // lamp does not stay lit for a cycle after the test is switched off.
      mode_lamp_ff <= (mode_press ? ~tape_micro_mode_ff : tape_micro_mode_ff)
                      | (wr_ctrl ? reg_wdata[CT_LAMP_TEST] : lamp_test_ff);
    end
  end

  // Clear pulse to the rest of the processor.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      system_clear_ff <= 1'b0;
    end else begin
      system_clear_ff <= clr_press;
    end
  end

  // Run state: start only leaves halt; clear and halt requests stop it.
  // Clear is meant for a halted machine, but it is honoured while running.
  always_comb begin
    nxt_run = run_ff;
    case (run_ff)
      OPC_HALTED: begin
        if (start_press && !clr_press) begin
          nxt_run = OPC_RUNNING;
        end
      end
      OPC_RUNNING: begin
        if (clr_press || halt_request) begin
          nxt_run = OPC_HALTED;
        end
      end
      default: begin
        nxt_run = OPC_HALTED;
      end
    endcase
  end

  // Run state register and its run enable output.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      run_ff <= OPC_HALTED;
      run_enable_ff <= 1'b0;
    end else begin
      run_ff <= nxt_run;
      run_enable_ff <= (nxt_run == OPC_RUNNING);
    end
  end

  // Attention flag: the button only sets it; microprogram, software or
  // clear reset it. A press in the reset cycle still leaves it set.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      operator_attention_flag_ff <= 1'b0;
    end else if (attn_press) begin
      operator_attention_flag_ff <= 1'b1;
    end else if (attention_flag_reset || sw_attn_reset || clr_press) begin
      operator_attention_flag_ff <= 1'b0;
    end
  end

  // Abnormal run condition for the lamp in the start button.
  always_comb begin
    test_cond = operator_attention_flag_ff | pin_sync_ff[PIN_SINGLE]
                | ({pin_sync_ff[PIN_SRC_HI], pin_sync_ff[PIN_SRC_LO]}
                   != MICRO_SRC_NORMAL);
  end

  // Test state lamp and beginning-of-tape lamp.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      test_state_lamp_ff <= 1'b0;
      tape_start_lamp_ff <= 1'b0;
    end else begin
      test_state_lamp_ff <= test_cond | lamp_test_ff;
      tape_start_lamp_ff <= pin_sync_ff[PIN_BOT] | lamp_test_ff;
    end
  end

  // Rewind is accepted in any run state; the drive handles a repeat.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rewind_start_ff <= 1'b0;
    end else begin
      rewind_start_ff <= rewind_press;
    end
  end

  // Micro fetch steering. Requests while halted are dropped so that a stray
  // sequencer strobe cannot load the micro register.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cache_fetch_ff <= 1'b0;
      mir_load_ff <= 1'b0;
      mir_data_ff <= '0;
    end else begin
      cache_fetch_ff <= micro_fetch_req && run_ff == OPC_RUNNING
                        && !tape_micro_mode_ff;
      mir_load_ff <= micro_fetch_req && run_ff == OPC_RUNNING
                     && tape_micro_mode_ff;
      if (micro_fetch_req && run_ff == OPC_RUNNING && tape_micro_mode_ff) begin
        mir_data_ff <= tape_word;
      end
    end
  end

  // Events raised this cycle.
  always_comb begin
    ev_now = '0;
    ev_now[EV_MODE] = mode_press;
    ev_now[EV_CLEAR] = clr_press;
    ev_now[EV_START] = start_press;
    ev_now[EV_ATTN] = attn_press;
    ev_now[EV_REWIND] = rewind_press;
    ev_now[EV_BOT] = bot_rise;
  end

  // Sticky events, write one to clear; a new event wins over the clear.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      event_ff <= '0;
    end else if (wr_event) begin
      event_ff <= (event_ff & ~reg_wdata[EV_COUNT-1:0]) | ev_now;
    end else begin
      event_ff <= event_ff | ev_now;
    end
  end

  // Mask and control registers. The state register is read only.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mask_ff <= MASK_RST;
      lamp_test_ff <= 1'b0;
    end else begin
      if (wr_mask) begin
        mask_ff <= reg_wdata[EV_COUNT-1:0];
      end
      if (wr_ctrl) begin
        lamp_test_ff <= reg_wdata[CT_LAMP_TEST];
      end
    end
  end

  // Level interrupt; registered, so it trails the event by one cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(event_ff & mask_ff);
    end
  end

  // Read data stand in the cycle after the strobe and only there.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_ff <= '0;
    end else begin
      reg_rdata_ff <= '0;
      if (reg_rd) begin
        case (reg_addr)
          OFS_STATE: begin
            reg_rdata_ff[ST_TAPE_MODE] <= tape_micro_mode_ff;
            reg_rdata_ff[ST_ATTN_FLAG] <= operator_attention_flag_ff;
            reg_rdata_ff[ST_RUNNING] <= (run_ff == OPC_RUNNING);
            reg_rdata_ff[ST_TEST_LAMP] <= test_cond;
            reg_rdata_ff[ST_BOT] <= pin_sync_ff[PIN_BOT];
          end
          OFS_EVENT: begin
            reg_rdata_ff[EV_COUNT-1:0] <= event_ff;
          end
          OFS_MASK: begin
            reg_rdata_ff[EV_COUNT-1:0] <= mask_ff;
          end
          OFS_CTRL: begin
            reg_rdata_ff[CT_LAMP_TEST] <= lamp_test_ff;
          end
          default: begin
            reg_rdata_ff <= '0;
          end
        endcase
      end
    end
  end

  // Checks kept beside the logic.
  a_mode_toggle: assert property (@(posedge clk_sys) disable iff (rst)
    mode_press |=> tape_micro_mode_ff != $past(tape_micro_mode_ff))
    else $error("mode did not toggle on press");
  a_mode_hold: assert property (@(posedge clk_sys) disable iff (rst)
    !mode_press |=> $stable(tape_micro_mode_ff))
    else $error("mode changed without press");
  a_mode_lamp: assert property (@(posedge clk_sys) disable iff (rst)
    !lamp_test_ff |-> mode_lamp_ff == tape_micro_mode_ff)
    else $error("mode lamp disagrees with mode");
  a_tape_fetch: assert property (@(posedge clk_sys) disable iff (rst)
    (micro_fetch_req && run_ff == OPC_RUNNING && tape_micro_mode_ff)
    |=> mir_load_ff && !cache_fetch_ff && mir_data_ff == $past(tape_word))
    else $error("tape fetch did not load micro register");
  a_cache_fetch: assert property (@(posedge clk_sys) disable iff (rst)
    (micro_fetch_req && run_ff == OPC_RUNNING && !tape_micro_mode_ff)
    |=> cache_fetch_ff && !mir_load_ff)
    else $error("normal fetch not sent to cache");
  a_start_run: assert property (@(posedge clk_sys) disable iff (rst)
    (run_ff == OPC_HALTED && start_press && !clr_press) |=> run_enable_ff)
    else $error("start from halt did not run");
  a_clear_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    clr_press |=> system_clear_ff ##1 !system_clear_ff)
    else $error("clear pulse wrong length");
  a_attn_set: assert property (@(posedge clk_sys) disable iff (rst)
    attn_press |=> operator_attention_flag_ff)
    else $error("attention press did not set flag");
  a_attn_keep: assert property (@(posedge clk_sys) disable iff (rst)
    (operator_attention_flag_ff && !attention_flag_reset && !sw_attn_reset && !clr_press)
    |=> operator_attention_flag_ff)
    else $error("attention flag lost without reset");
  a_test_lamp: assert property (@(posedge clk_sys) disable iff (rst)
    pin_sync_ff[PIN_SINGLE] |=> test_state_lamp_ff)
    else $error("test lamp dark in single step");
  a_rewind_any: assert property (@(posedge clk_sys) disable iff (rst)
    rewind_press |=> rewind_start_ff)
    else $error("rewind press ignored");
  a_bot_lamp: assert property (@(posedge clk_sys) disable iff (rst)
    pin_sync_ff[PIN_BOT] |=> tape_start_lamp_ff)
    else $error("beginning lamp dark");
  a_one_pulse: assert property (@(posedge clk_sys) disable iff (rst)
    start_press |=> !start_press)
    else $error("start press gave two pulses");

endmodule : opc_panel
`default_nettype wire

// ---- common/opc_pkg.sv ----
// Constants shared by the operator panel control logic.
// Assumes a single 200 MHz system clock and a plain register port.
package opc_pkg;

  // Positions of the asynchronous panel inputs in the synchroniser vector.
  localparam int PIN_MODE = 0;
  localparam int PIN_CLR_OP = 1;
  localparam int PIN_CLR_MNT = 2;
  localparam int PIN_START_OP = 3;
  localparam int PIN_START_MNT = 4;
  localparam int PIN_ATTN_OP = 5;
  localparam int PIN_ATTN_MNT = 6;
  localparam int PIN_REWIND = 7;
  localparam int PIN_BOT = 8;
  localparam int PIN_SINGLE = 9;
  localparam int PIN_SRC_LO = 10;
  localparam int PIN_SRC_HI = 11;
  localparam int PIN_COUNT = 12;

  // Register byte offsets on the 4-bit address port.
  localparam logic [3:0] OFS_STATE = 4'h0;
  localparam logic [3:0] OFS_EVENT = 4'h4;
  localparam logic [3:0] OFS_MASK = 4'h8;
  localparam logic [3:0] OFS_CTRL = 4'hC;

  // Event bit positions, shared by the event and mask registers.
  localparam int EV_MODE = 0;
  localparam int EV_CLEAR = 1;
  localparam int EV_START = 2;
  localparam int EV_ATTN = 3;
  localparam int EV_REWIND = 4;
  localparam int EV_BOT = 5;
  localparam int EV_COUNT = 6;

  // State register field positions.
  localparam int ST_TAPE_MODE = 0;
  localparam int ST_ATTN_FLAG = 1;
  localparam int ST_RUNNING = 2;
  localparam int ST_TEST_LAMP = 3;
  localparam int ST_BOT = 4;

  // Control register field positions.
  localparam int CT_ATTN_RESET = 0;
  localparam int CT_LAMP_TEST = 1;

  // Mask reset value and the normal micro source selection.
  localparam logic [EV_COUNT-1:0] MASK_RST = 6'h00;
  localparam logic [1:0] MICRO_SRC_NORMAL = 2'h0;

  // Run sequencing states, one-hot.
  typedef enum logic [1:0] {
    OPC_HALTED = 2'h1,
    OPC_RUNNING = 2'h2
  } opc_run_t;

endpackage : opc_pkg

// ---- bench/opc_operator_model.sv ----
// Operator at the panel: presses and releases the pushbuttons on command.
// Assumes the bench raises a press request for one clk_sys cycle per press.
`timescale 1ns/1ps
`default_nettype none
module opc_operator_model (
  input wire logic clk_sys,
  input wire logic [7:0] press_req,
  output logic [7:0] pins
);
  // Cycles left on each held button.
  logic [2:0] hold [8];

  // A press holds the contact closed for four cycles, then opens it.
  // Opening before the next press lets every press be counted alone.
  initial begin
    pins = 8'h00;
    for (int i = 0; i < 8; i++) begin
      hold[i] = 3'h0;
    end
  end
  always @(posedge clk_sys) begin
    for (int i = 0; i < 8; i++) begin
      if (press_req[i]) begin
        hold[i] <= 3'h4;
        pins[i] <= 1'b1;
      end else if (hold[i] != 3'h0) begin
        hold[i] <= hold[i] - 3'h1;
        pins[i] <= (hold[i] != 3'h1);
      end else begin
        pins[i] <= 1'b0;
      end
    end
  end
endmodule : opc_operator_model
`default_nettype wire

// ---- bench/opc_panel_tb.sv ----
// Self-checking bench for the operator panel control block.
// Assumes the operator model drives the eight pushbutton pins.
`timescale 1ns/1ps
`default_nettype none
module opc_panel_tb import opc_pkg::*;;
  logic clk_sys = 1'b0, rst = 1'b1;
  logic [7:0] press_req = 8'h00, pins;
  logic tape_start_lamp = 1'b0, single = 1'b0, halt_request = 1'b0, attn_rst = 1'b0, fetch = 1'b0;
  logic [1:0] src = 2'h0;
  logic [23:0] tape_word = 24'h000000;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [31:0] reg_rdata_ff;
  logic irq_ff, tmm, lamp, clr_p, run, test_lamp, flag, rew_p, bot_lamp, cf, ml;
  logic [23:0] mir;
  int fail_count = 0, checks_done = 0, n_clr = 0, n_rew = 0, c0, r0;

  // Clock at 200 MHz.
  initial forever #2.5 clk_sys = ~clk_sys;

  opc_operator_model u_op (.clk_sys(clk_sys), .press_req(press_req), .pins(pins));
  opc_panel u_dut (.clk_sys(clk_sys), .rst(rst), .mode_button(pins[PIN_MODE]),
    .clear_button_op(pins[PIN_CLR_OP]), .clear_button_mnt(pins[PIN_CLR_MNT]),
    .start_button_op(pins[PIN_START_OP]), .start_button_mnt(pins[PIN_START_MNT]),
    .attention_button_op(pins[PIN_ATTN_OP]), .attention_button_mnt(pins[PIN_ATTN_MNT]),
    .tape_rewind_button(pins[PIN_REWIND]), .tape_bot_sense(tape_start_lamp),
    .single_step_select(single), .micro_source_sel(src), .halt_request(halt_request),
    .attention_flag_reset(attn_rst), .micro_fetch_req(fetch), .tape_word(tape_word),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .irq_ff(irq_ff), .tape_micro_mode_ff(tmm),
    .mode_lamp_ff(lamp), .system_clear_ff(clr_p), .run_enable_ff(run),
    .test_state_lamp_ff(test_lamp), .operator_attention_flag_ff(flag),
    .rewind_start_ff(rew_p), .tape_start_lamp_ff(bot_lamp), .cache_fetch_ff(cf),
    .mir_load_ff(ml), .mir_data_ff(mir));

  // Pulse outputs last one cycle, so they are counted on every edge.
  always @(posedge clk_sys) begin
    n_clr <= n_clr + int'(clr_p === 1'b1);
    n_rew <= n_rew + int'(rew_p === 1'b1);
  end

  // Compares a value, padded to a word, with its expectation.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One press of the buttons in the mask, then time for the result to settle.
  task automatic press(input logic [7:0] m);
    @(posedge clk_sys);
    press_req <= m;
    @(posedge clk_sys);
    press_req <= 8'h00;
    repeat (12) @(posedge clk_sys);
    #1;
  endtask : press

  // Register write and read, one strobe cycle each.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_ff;
  endtask : rd

  // One micro fetch request; the answer is looked at in the following cycle.
  task automatic do_fetch(input logic [23:0] w);
    @(posedge clk_sys);
    fetch <= 1'b1;
    tape_word <= w;
    @(posedge clk_sys);
    fetch <= 1'b0;
    #1;
  endtask : do_fetch

  // Mode toggles, its lamp follows, and the event raises a masked interrupt.
  task automatic t_mode();
    press(8'h01);
    chk("mode", 32'h1, tmm);
    chk("mode lamp", 32'h1, lamp);
    chk("irq masked", 32'h0, irq_ff);
    wr(OFS_MASK, 32'h01);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq", 32'h1, irq_ff);
    rd(OFS_MASK, rdata);
    chk("mask", 32'h01, rdata);
    wr(OFS_EVENT, 32'h3F);
    repeat (2) @(posedge clk_sys);
    #1 chk("irq clear", 32'h0, irq_ff);
    rd(4'h2, rdata);
    chk("unmapped", 32'h0, rdata);
    press(8'h01);
    chk("mode back", 32'h0, tmm);
    chk("lamp back", 32'h0, lamp);
    $display("test mode done");
  endtask : t_mode

  // Fetches are dropped while halted; start runs, both modes then fetch.
  task automatic t_run();
    do_fetch(24'hA5A5A5);
    chk("halted fetch", 32'h0, {ml, cf});
    press(8'h10);
    chk("run", 32'h1, run);
    do_fetch(24'h123456);
    chk("cache fetch", 32'h1, cf);
    press(8'h01);
    do_fetch(24'hC0FFEE);
    chk("mir load", 32'h1, ml);
    chk("mir data", 32'hC0FFEE, mir);
    @(posedge clk_sys);
    #1 chk("mir pulse", 32'h0, ml);
    press(8'h01);
    $display("test run done");
  endtask : t_run

  // Attention from both panels: set only, never cleared by the button.
  task automatic t_attn();
    press(8'h40);
    chk("flag", 32'h1, flag);
    chk("test lamp", 32'h1, test_lamp);
    press(8'h20);
    chk("flag kept", 32'h1, flag);
    rd(OFS_STATE, rdata);
    chk("state flag", 32'h1, rdata[ST_ATTN_FLAG]);
    @(posedge clk_sys);
    attn_rst <= 1'b1;
    @(posedge clk_sys);
    attn_rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk("flag reset", 32'h0, flag);
    chk("lamp off", 32'h0, test_lamp);
    single <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 chk("lamp single", 32'h1, test_lamp);
    single <= 1'b0;
    src <= 2'h2;
    repeat (6) @(posedge clk_sys);
    #1 chk("lamp source", 32'h1, test_lamp);
    src <= 2'h0;
    repeat (6) @(posedge clk_sys);
    $display("test attention done");
  endtask : t_attn

  // Clear from both panels at once gives one pulse and halts; rewind any time.
  task automatic t_clear_rewind();
    c0 = n_clr;
    r0 = n_rew;
    press(8'h80);
    press(8'h06);
    chk("clear pulses", 32'(c0 + 1), 32'(n_clr));
    chk("halted", 32'h0, run);
    press(8'h08);
    chk("start op", 32'h1, run);
    @(posedge clk_sys);
    halt_request <= 1'b1;
    @(posedge clk_sys);
    halt_request <= 1'b0;
    #1 chk("halt request", 32'h0, run);
    press(8'h10);
    chk("restart mnt", 32'h1, run);
    press(8'h04);
    chk("clear mnt", 32'h0, run);
    press(8'h80);
    chk("rewinds", 32'(r0 + 2), 32'(n_rew));
    tape_start_lamp <= 1'b1;
    repeat (6) @(posedge clk_sys);
    #1 chk("bot lamp", 32'h1, bot_lamp);
    tape_start_lamp <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 chk("bot lamp off", 32'h0, bot_lamp);
    $display("test clear and rewind done");
  endtask : t_clear_rewind

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    t_mode();
    t_run();
    t_attn();
    t_clear_rewind();
    conclude();
  end

  // The tests take well under a thousand cycles; this cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    conclude();
  end
endmodule : opc_panel_tb
`default_nettype wire
